// ===== design/uglr_glyph_ram.sv
// Glyph memory: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module uglr_glyph_ram (
  input  wire logic                          clk,
  input  wire logic                          ce,
  input  wire logic                          we,
  input  wire logic [uglr_pkg::ADDR_W-1:0]   waddr,
  input  wire logic [uglr_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          re,
  input  wire logic [uglr_pkg::ADDR_W-1:0]   raddr,
  output var  logic [uglr_pkg::DATA_W-1:0]   rdata
);
  logic [uglr_pkg::DATA_W-1:0] mem [uglr_pkg::DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : uglr_glyph_ram
`default_nettype wire

// ===== design/uglr_lookup.sv
// User glyph lookup: code to glyph row, cursor merge, dot output
`timescale 1ns/1ps
`default_nettype none
module uglr_lookup (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic                          font_5x10,
  input  wire logic                          host_we,
  input  wire logic [uglr_pkg::ADDR_W-1:0]   host_addr,
  input  wire logic [uglr_pkg::DATA_W-1:0]   host_wdata,
  input  wire logic                          disp_req,
  input  wire logic [7:0]                    disp_code,
  input  wire logic [3:0]                    disp_row,
  input  wire logic                          disp_cursor,
  output var  logic                          dots_valid,
  output var  logic                          dots_user,
  output var  logic [uglr_pkg::DOT_W-1:0]    dots
);
  typedef enum logic [1:0] {
    UGLR_IDLE  = 2'b01,
    UGLR_FETCH = 2'b10
  } uglr_state_e;

  uglr_state_e                   state;
  uglr_state_e                   next_state;
  logic                          cur_q;
  logic                          last_q;
  logic                          user_q;
  logic                          blank_q;
  logic [uglr_pkg::DATA_W-1:0]   rd_data;

  wire        code_user   = (disp_code[7:4] == uglr_pkg::USER_HI_CODE);
  wire [5:0]  addr_5x8    = {disp_code[2:0], disp_row[2:0]};
  wire [5:0]  addr_5x10   = {disp_code[2:1], disp_row[3:0]};
  wire [5:0]  rd_addr     = font_5x10 ? addr_5x10 : addr_5x8;
  wire        row_ok      = font_5x10 ? (disp_row < uglr_pkg::ROWS_5X10)
                                      : (disp_row < uglr_pkg::ROWS_5X8);
  wire        is_cur_row  = font_5x10 ? (disp_row == uglr_pkg::CURSOR_5X10)
                                      : (disp_row == uglr_pkg::CURSOR_5X8);
  wire        rd_en       = disp_req && code_user && row_ok;
  wire [4:0]  row_bits    = rd_data[4:0];
  wire [4:0]  cursor_bits = {5{cur_q && last_q}};
  wire [4:0]  merged      = blank_q ? uglr_pkg::DOTS_RESET
                                    : (row_bits | cursor_bits);

  // Separate read port: host writes never stall or disturb a display read
  uglr_glyph_ram u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (host_we),
    .waddr (host_addr),
    .wdata (host_wdata),
    .re    (rd_en),
    .raddr (rd_addr),
    .rdata (rd_data)
  );

  always_comb begin
    next_state = state;
    case (state)
      UGLR_IDLE: begin
        if (disp_req) begin
          next_state = UGLR_FETCH;
        end
      end
      UGLR_FETCH: begin
        if (!disp_req) begin
          next_state = UGLR_IDLE;
        end
      end
      default: begin
        next_state = UGLR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state   <= UGLR_IDLE;
      cur_q   <= 1'b0;
      last_q  <= 1'b0;
      user_q  <= 1'b0;
      blank_q <= 1'b1;
    end else if (ce) begin
      state   <= next_state;
      if (disp_req) begin
        cur_q   <= disp_cursor;
        last_q  <= is_cur_row;
        user_q  <= code_user;
        blank_q <= !rd_en;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dots_valid <= 1'b0;
      dots_user  <= 1'b0;
      dots       <= uglr_pkg::DOTS_RESET;
    end else if (ce) begin
      dots_valid <= (state == UGLR_FETCH);
      dots_user  <= user_q;
      dots       <= merged;
    end
  end
endmodule : uglr_lookup
`default_nettype wire

// ===== design/uglr_pkg.sv
// Constants shared by the user glyph lookup block
// Summary of operation
// - In 5x8 format code bits 0 to 2 become glyph address bits 3 to 5, giving eight glyphs.
// - A glyph data bit of one lights its dot and a zero leaves it dark.
// - In 5x8 format glyph address bits 0 to 2 pick the row within the glyph.
// - In 5x8 format the eighth row is the cursor row, shown as stored data OR cursor.
// - The user glyph memory replaces the fixed font whenever code bits 4 to 7 are zero.
// - In 5x8 format code bit 3 is ignored, so codes 00H and 08H show one glyph.
// - Row dots come from data bits 0 to 4 with bit 4 leftmost; higher bits are ignored.
// - In 5x10 format code bits 1 and 2 become glyph address bits 4 and 5, giving four glyphs.
// - In 5x10 format glyph address bits 0 to 3 pick the row within the glyph.
// - In 5x10 format the eleventh row is the cursor row, shown as stored data OR cursor.
// - In 5x10 format code bits 0 and 3 are ignored, so 00H, 01H, 08H and 09H match.
// - Display reads use slots apart from host accesses so host writes cause no flicker.
package uglr_pkg;
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 8;
  localparam int          DOT_W        = 5;
  localparam int          DEPTH        = 64;
  localparam logic [3:0]  ROWS_5X8     = 4'h8;
  localparam logic [3:0]  ROWS_5X10    = 4'hB;
  localparam logic [3:0]  CURSOR_5X8   = 4'h7;
  localparam logic [3:0]  CURSOR_5X10  = 4'hA;
  localparam logic [3:0]  USER_HI_CODE = 4'h0;
  localparam logic [4:0]  DOTS_RESET   = 5'h00;
  localparam logic [7:0]  CODE_RESET   = 8'h00;
  localparam logic [5:0]  ADDR_RESET   = 6'h00;
endpackage : uglr_pkg

// ===== verification/test_user_glyph_ram_lookup.sv
// Self-checking bench for the user glyph lookup
`timescale 1ns/1ps
`default_nettype none
module test_user_glyph_ram_lookup;
  logic clk = 0, rstn = 0, ce = 1, font = 0, req = 0, cur = 0;
  logic [7:0] code = 8'h00;
  logic [3:0] row = 4'h0;
  wire logic we, dv, du;
  wire logic [5:0] ha;
  wire logic [7:0] hd;
  wire logic [4:0] dots;
  int n_errors = 0, check_count = 0;
  always #25 clk = ~clk;
  uglr_host uglr_host_inst (.clk(clk), .we(we), .addr(ha), .data(hd));
  uglr_lookup uglr_lookup_inst (.clk(clk), .rstn(rstn), .ce(ce),
    .font_5x10(font), .host_we(we), .host_addr(ha), .host_wdata(hd),
    .disp_req(req), .disp_code(code), .disp_row(row), .disp_cursor(cur),
    .dots_valid(dv), .dots_user(du), .dots(dots));
  task chk(input logic [4:0] s, input logic [4:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++; $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task rd(input logic [7:0] c, input logic [3:0] r, input logic k,
          input logic [4:0] e);
    @(posedge clk); req <= 1'b1; code <= c; row <= r; cur <= k;
    @(posedge clk); req <= 1'b0; code <= ~c; row <= ~r; cur <= ~k;
    @(posedge clk);
    #1 chk({4'h0, dv}, 5'h01);
    @(posedge clk);
    #1 chk(dots, e);
    chk({4'h0, du}, {4'h0, c[7:4] == 4'h0});
    chk({4'h0, dv}, 5'h00);
  endtask : rd
  task t_5x8;
    font <= 1'b0;
    for (int r = 0; r < 8; r++)
      uglr_host_inst.wr({3'h1, 3'(r)}, r == 7 ? 8'hE0 : {3'h7, 5'(r*5+1)});
    for (int r = 0; r < 9; r++)
      rd(8'h09, 4'(r), 1'b0, r < 7 ? 5'(r*5+1) : 5'h00);
    rd(8'h01, 4'h7, 1'b1, 5'h1F);
  endtask : t_5x8
  task t_5x10;
    font <= 1'b1;
    for (int r = 0; r < 11; r++)
      uglr_host_inst.wr({2'h1, 4'(r)}, r == 10 ? 8'h00 : {3'h5, 5'(r*3+2)});
    for (int r = 0; r < 16; r++)
      rd(8'h0B, 4'(r), 1'b0, r < 10 ? 5'(r*3+2) : 5'h00);
    rd(8'h03, 4'hA, 1'b1, 5'h1F);
  endtask : t_5x10
  task t_other;
    rd(8'h18, 4'h1, 1'b1, 5'h00);
    rd(8'hF3, 4'hA, 1'b1, 5'h00);
  endtask : t_other
  task conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_5x8;
    t_5x10;
    t_other;
    conclude;
  end
endmodule : test_user_glyph_ram_lookup
`default_nettype wire

// ===== verification/uglr_host.sv
// Host processor model that writes the glyph memory
`timescale 1ns/1ps
`default_nettype none
module uglr_host (
  input  wire logic       clk,
  output var  logic       we,
  output var  logic [5:0] addr,
  output var  logic [7:0] data
);
  initial begin
    we = 1'b0;
    addr = 6'h00;
    data = 8'h00;
  end
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk); we <= 1'b1; addr <= a; data <= d;
    @(posedge clk); we <= 1'b0; addr <= ~a; data <= ~d;
  endtask : wr
endmodule : uglr_host
`default_nettype wire

// ===== verification/uglr_lookup_checker.sv
// Port checks for the user glyph lookup
`timescale 1ns/1ps
`default_nettype none
module uglr_lookup_checker (
  input wire logic       clk, rstn, ce, font_5x10, disp_req, disp_cursor,
  input wire logic [7:0] disp_code,
  input wire logic [3:0] disp_row,
  input wire logic       dots_valid, dots_user,
  input wire logic [4:0] dots
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire t = disp_req && ce;
  wire u = disp_code[7:4] == 4'h0;
  AST_USER: assert property (t ##1 ce[*2] |=> dots_user == $past(u, 3))
    else $error("user flag wrong");
  AST_OTHER: assert property (t && !u ##1 ce[*2] |=> dots == 5'h00)
    else $error("fixed font code lit dots");
  AST_ROW8: assert property (t && !font_5x10 && disp_row[3] ##1 ce[*2]
    |=> dots == 5'h00) else $error("row past 5x8 glyph lit");
  AST_ROW10: assert property (t && font_5x10 && disp_row > 4'hA
    ##1 ce[*2] |=> dots == 5'h00) else $error("row past 5x10 glyph lit");
  AST_CUR8: assert property (t && u && !font_5x10 && disp_row == 4'h7
    && disp_cursor ##1 ce[*2] |=> dots == 5'h1F) else $error("cursor 5x8");
  AST_CUR10: assert property (t && u && font_5x10 && disp_row == 4'hA
    && disp_cursor ##1 ce[*2] |=> dots == 5'h1F) else $error("cursor 5x10");
  AST_DUSER: assert property (dots != 5'h00 |-> dots_user)
    else $error("dots lit without user glyph");
  AST_VALID: assert property (dots_valid |-> $past(disp_req, 2)
    || $past(disp_req, 3)) else $error("valid without request");
endmodule : uglr_lookup_checker
bind uglr_lookup uglr_lookup_checker uglr_lookup_checker_inst (.clk(clk),
  .rstn(rstn), .ce(ce), .font_5x10(font_5x10), .disp_req(disp_req),
  .disp_cursor(disp_cursor), .disp_code(disp_code), .disp_row(disp_row),
  .dots_valid(dots_valid), .dots_user(dots_user), .dots(dots));
`default_nettype wire
